// ---- pkg/brw_pkg.sv ----
// package: constants and types of the board reset and watchdog unit
// ==========================================================================
// How it works
// - timeout programmable from 12 to 1600 ms
// - expiry pulses reset for about 130 ms
// - software enables, retriggers, disables with key
// - restart from address zero, peripherals reset
// - active-low reset driven to expansion connector
// - power-good, programming port, contact also reset
// - closed contact holds reset while closed
// - watchdog reset leaves expansion line released
// - reset cause flag marks watchdog resets
// ==========================================================================
package brw_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 40_000_000;
  // timing figures in milliseconds
  localparam int unsigned TMO_MIN_MS = 12;
  localparam int unsigned TMO_MAX_MS = 1600;
  localparam int unsigned RST_PULSE_MS = 130;
  // cycles per millisecond
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned RST_PULSE_CYC = RST_PULSE_MS * CYC_PER_MS;
  // width of the timeout field in milliseconds
  localparam int unsigned TMO_W = 11;
  localparam logic [TMO_W-1:0] TMO_MIN = 11'h00c;
  localparam logic [TMO_W-1:0] TMO_MAX = 11'h640;
  // width of the millisecond prescaler and pulse counter
  localparam int unsigned PRE_W = 16;
  localparam int unsigned PULSE_W = 23;
  localparam logic [PRE_W-1:0] PRE_LAST = 16'h9c3f;
  // disable key that must accompany a disable request
  localparam logic [7:0] DIS_KEY = 8'ha5;
  // program restart address after reset
  localparam logic [16:0] BOOT_ADDR = 17'h00000;

  // software command group
  typedef struct packed {
    logic enable;
    logic retrigger;
    logic disarm;
    logic [7:0] key;
    logic [TMO_W-1:0] timeout;
  } brw_cmd_t;

  // external reset sources, all active high when asserting
  typedef struct packed {
    logic powerFail;
    logic ispReset;
    logic contactClosed;
  } brw_src_t;

  // states of the reset pulse machine
  typedef enum logic [1:0] {
    ST_RUN,
    ST_WDOG_RST,
    ST_EXT_RST
  } brw_state_t;
endpackage : brw_pkg

// ---- hdl/brw_ms_tick.sv ----
// file: millisecond tick generator
`timescale 1ns/10ps
module brw_ms_tick
  import brw_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clear,
  output logic tick
);
  logic [PRE_W-1:0] count;
  wire logic atLast = (count == PRE_LAST);

  // prescaler: restarted by clear so a retrigger spans full milliseconds
  always_ff @(posedge core_clk) begin
    if (srst || clear || atLast) begin
      count <= '0;
    end else begin
      count <= count + 16'h0001;
    end
  end

  // one-cycle pulse once per millisecond
  always_ff @(posedge core_clk) begin
    if (srst || clear) begin
      tick <= 1'b0;
    end else begin
      tick <= atLast;
    end
  end

  tick_period_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(tick) |-> ##1 !tick) else $error("tick longer than one cycle");
endmodule : brw_ms_tick

// ---- hdl/brw_reset_watchdog.sv ----
// file: top of the board reset and watchdog unit
`timescale 1ns/10ps
module brw_reset_watchdog
  import brw_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire brw_cmd_t cmd,
  input wire brw_src_t src,
  input wire logic causeClear,
  output logic sysReset,
  output logic expResetN,
  output logic periphReset,
  output logic [16:0] bootAddr,
  output logic wdogEnabled,
  output logic reset_cause_status
);
  // ==========================================================================
  // decoding
  // ==========================================================================
  brw_state_t state;
  brw_state_t next_state;
  logic [TMO_W-1:0] timeout;
  logic [TMO_W-1:0] msCount;
  logic [PULSE_W-1:0] pulseCount;
  logic tick;

  function automatic logic [TMO_W-1:0] clampTmo(input logic [TMO_W-1:0] v);
    if (v < TMO_MIN) return TMO_MIN;
    if (v > TMO_MAX) return TMO_MAX;
    return v;
  endfunction : clampTmo

  wire logic anyExt = src.powerFail | src.ispReset | src.contactClosed;
  wire logic inRun = (state == ST_RUN);
  wire logic disOk = cmd.disarm && (cmd.key == DIS_KEY);
  wire logic kick = inRun && (cmd.retrigger || (cmd.enable && !wdogEnabled));
  wire logic expired = inRun && wdogEnabled && tick && (msCount + 11'h001 >= timeout);
  wire logic pulseDone = (pulseCount == PULSE_W'(RST_PULSE_CYC - 1));

  brw_ms_tick u_tick (
    .core_clk(core_clk),
    .srst(srst),
    .clear(kick || !inRun),
    .tick(tick)
  );

  // ==========================================================================
  // reset sequencing
  // ==========================================================================
  // next state: external sources outrank the watchdog pulse
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (anyExt) begin
          next_state = ST_EXT_RST;
        end else if (expired) begin
          next_state = ST_WDOG_RST;
        end
      end
      ST_WDOG_RST: begin
        if (anyExt) begin
          next_state = ST_EXT_RST;
        end else if (pulseDone) begin
          next_state = ST_RUN;
        end
      end
      ST_EXT_RST: begin
        if (!anyExt) begin
          next_state = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // pulse counter runs only inside the watchdog pulse
  always_ff @(posedge core_clk) begin
    if (srst || state != ST_WDOG_RST) begin
      pulseCount <= '0;
    end else begin
      pulseCount <= pulseCount + 23'h000001;
    end
  end

  // ==========================================================================
  // watchdog control
  // ==========================================================================
  // enable and disable; a reset pulse disables the watchdog again
  always_ff @(posedge core_clk) begin
    if (srst || !inRun) begin
      wdogEnabled <= 1'b0;
    end else if (cmd.enable) begin
      wdogEnabled <= 1'b1;
    end else if (disOk) begin
      wdogEnabled <= 1'b0;
    end
  end

  // timeout latched on enable, clamped to the legal range
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timeout <= TMO_MAX;
    end else if (cmd.enable && inRun) begin
      timeout <= clampTmo(cmd.timeout);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || kick || !inRun || !wdogEnabled) begin
      msCount <= '0;
    end else if (tick) begin
      msCount <= msCount + 11'h001;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sysReset <= 1'b1;
      expResetN <= 1'b0;
      periphReset <= 1'b1;
      bootAddr <= BOOT_ADDR;
    end else begin
      sysReset <= (next_state != ST_RUN);
      // expansion line follows only external causes
      expResetN <= (next_state != ST_EXT_RST);
      // peripherals held in reset, restart at zero
      periphReset <= (next_state != ST_RUN);
      bootAddr <= BOOT_ADDR;
    end
  end

  // sticky cause flag; a new watchdog expiry wins over a clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reset_cause_status <= 1'b0;
    end else if (expired && !anyExt) begin
      reset_cause_status <= 1'b1;
    end else if (causeClear || (state == ST_EXT_RST)) begin
      reset_cause_status <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  wdog_no_exp_a: assert property (@(posedge core_clk) disable iff (srst)
    state == ST_WDOG_RST |-> expResetN) else $error("watchdog drove expansion reset");
  ext_exp_a: assert property (@(posedge core_clk) disable iff (srst)
    state == ST_EXT_RST |-> !expResetN) else $error("expansion reset missing");
  contact_hold_a: assert property (@(posedge core_clk) disable iff (srst)
    src.contactClosed |=> sysReset) else $error("contact did not hold reset");
  src_reset_a: assert property (@(posedge core_clk) disable iff (srst)
    anyExt |=> state == ST_EXT_RST) else $error("source did not reset");
  expire_rst_a: assert property (@(posedge core_clk) disable iff (srst)
    expired && !anyExt |=> sysReset && reset_cause_status) else $error("no watchdog reset");
  pulse_end_a: assert property (@(posedge core_clk) disable iff (srst)
    state == ST_WDOG_RST && pulseDone && !anyExt |=> state == ST_RUN)
    else $error("pulse did not end");
  tmo_range_a: assert property (@(posedge core_clk) disable iff (srst)
    timeout >= TMO_MIN && timeout <= TMO_MAX) else $error("timeout out of range");
  bad_key_a: assert property (@(posedge core_clk) disable iff (srst)
    inRun && wdogEnabled && cmd.disarm && cmd.key != DIS_KEY && !cmd.enable |=> wdogEnabled)
    else $error("unkeyed disable took effect");
  retrig_clr_a: assert property (@(posedge core_clk) disable iff (srst)
    kick && inRun && !anyExt |=> msCount == 11'h000) else $error("retrigger kept count");
  boot_zero_a: assert property (@(posedge core_clk) disable iff (srst)
    $fell(sysReset) |-> bootAddr == BOOT_ADDR && !periphReset) else $error("bad restart");
  wdog_reset_c: cover property (@(posedge core_clk) disable iff (srst)
    state == ST_WDOG_RST ##1 state == ST_RUN);
  contact_c: cover property (@(posedge core_clk) disable iff (srst)
    src.contactClosed ##1 !src.contactClosed);
  retrig_c: cover property (@(posedge core_clk) disable iff (srst)
    wdogEnabled && cmd.retrigger);
endmodule : brw_reset_watchdog

// ---- tb/brw_exp_card.sv ----
// file: stand-in expansion card that watches the expansion reset line
`timescale 1ns/10ps
module brw_exp_card
  import brw_pkg::*;
(
  input wire logic core_clk,
  input wire logic expResetN,
  output logic cardInReset,
  output int resetCount
);
  // ==========================================================================
  // card reset tracking
  // card follows line
  // any level other than a clean high resets the card, as a real card would
  initial begin
    cardInReset = 1'b0;
    resetCount = 0;
  end
  always @(posedge core_clk) begin
    cardInReset <= (expResetN !== 1'b1);
    if ((expResetN !== 1'b1) && !cardInReset) begin
      resetCount <= resetCount + 1; // one count per entry into reset
    end
  end
endmodule : brw_exp_card

// ---- tb/tb_board_reset_watchdog.sv ----
// file: self-checking bench of the board reset and watchdog unit
`timescale 1ns/10ps
module tb_board_reset_watchdog
  import brw_pkg::*;
;
  `define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t %s", $time, m); end end
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic causeClear = 1'b0;
  brw_cmd_t cmd = '0;
  brw_src_t src = '0;
  logic sysReset, expResetN, periphReset, wdogEnabled, reset_cause_status, cardInReset;
  logic [16:0] bootAddr;
  logic [7:0] key;
  int bad_count = 0, checks_done = 0, cycles = 0, cardCount, expCount = 1;

  brw_reset_watchdog dut (
    .core_clk(core_clk),
    .srst(srst),
    .cmd(cmd),
    .src(src),
    .causeClear(causeClear),
    .sysReset(sysReset),
    .expResetN(expResetN),
    .periphReset(periphReset),
    .bootAddr(bootAddr),
    .wdogEnabled(wdogEnabled),
    .reset_cause_status(reset_cause_status)
  );
  brw_exp_card card (
    .core_clk(core_clk),
    .expResetN(expResetN),
    .cardInReset(cardInReset),
    .resetCount(cardCount)
  );

  // ==========================================================================
  // clock and hang guard; ceiling is well above the planned run
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end

  // ==========================================================================
  // one-cycle command pulse, launched at an edge, then settled
  task automatic drive(input logic en, rt, dis, input logic [7:0] k, input logic [10:0] t);
    @(posedge core_clk);
    cmd <= '{en, rt, dis, k, t};
    causeClear <= rt;
    @(posedge core_clk);
    cmd <= '0;
    causeClear <= 1'b0;
    #1;
  endtask : drive

  // hold a reset source for n+1 cycles, checking the outputs in each of the first n
  task automatic src_case(input brw_src_t s, input int n);
    drive(1'b1, 1'b0, 1'b0, 8'h00, TMO_MIN);
    @(posedge core_clk);
    src <= s;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      `CHK(sysReset, 1'b1, "source did not reset")
      `CHK(periphReset, 1'b1, "peripherals not reset")
      `CHK(expResetN, 1'b0, "expansion line not low")
    end
    @(posedge core_clk);
    src <= '0;
    @(posedge core_clk);
    #1;
    `CHK(sysReset, 1'b0, "reset not released")
    `CHK(expResetN, 1'b1, "expansion line stuck")
    `CHK(bootAddr, 17'h00000, "restart address wrong")
    `CHK(wdogEnabled, 1'b0, "reset left watchdog armed")
    `CHK(reset_cause_status, 1'b0, "cause set by outside reset")
    expCount++;
  endtask : src_case

  // closing report, reached from the main sequence or the hang guard
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(70292));
    repeat (4) @(posedge core_clk);
    #1;
    `CHK({sysReset, periphReset, expResetN}, 3'b110, "reset state wrong")
    @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK({sysReset, expResetN, bootAddr}, {2'b01, 17'h00000}, "release state")
    $display("test reset done");
    drive(1'b1, 1'b0, 1'b0, 8'h00, 11'($urandom_range(0, 2047)));
    `CHK(wdogEnabled, 1'b1, "enable ignored")
    repeat (30) begin
      repeat ($urandom_range(0, 200)) @(posedge core_clk);
      drive(1'b0, 1'b1, 1'b0, 8'h00, 11'h000);
      `CHK({sysReset, wdogEnabled}, 2'b01, "retriggered watchdog fired")
      `CHK(dut.u_tick.count, 16'h0000, "prescaler not restarted")
    end
    repeat (8) begin
      key = 8'($urandom_range(0, 255));
      if (key == DIS_KEY) key = 8'h5a;
      drive(1'b0, 1'b0, 1'b1, key, 11'h000);
      `CHK(wdogEnabled, 1'b1, "disable took wrong key")
    end
    drive(1'b1, 1'b0, 1'b1, DIS_KEY, TMO_MAX);
    `CHK(wdogEnabled, 1'b1, "enable lost to disable")
    drive(1'b0, 1'b0, 1'b1, DIS_KEY, 11'h000);
    `CHK(wdogEnabled, 1'b0, "keyed disable ignored")
    $display("test software control done");
    src_case(3'b100, 1);
    src_case(3'b010, 2);
    src_case(3'b001, 40);
    repeat (12) src_case(brw_src_t'(3'($urandom_range(1, 7))), $urandom_range(1, 40));
    step_card();
    $display("test reset sources done");
    test_done();
  end

  task automatic step_card();
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(cardCount, expCount, "card reset count")
  endtask : step_card
endmodule : tb_board_reset_watchdog
